// *** inc/ioxp_params.svh ***
// register offsets, reset values and field sizes of the port data register core
`ifndef IOXP_PARAMS_SVH
`define IOXP_PARAMS_SVH

`define IOXP_PORT_W        8
`define IOXP_CMD_W         4
`define IOXP_OFS_LEVEL0    4'h0
`define IOXP_OFS_LEVEL1    4'h1
`define IOXP_OFS_DRIVE0    4'h2
`define IOXP_OFS_DRIVE1    4'h3
`define IOXP_OFS_INVERT0   4'h4
`define IOXP_OFS_INVERT1   4'h5
`define IOXP_OFS_LAST_OWN  4'h5
`define IOXP_RST_DRIVE     8'hFF
`define IOXP_RST_INVERT    8'h00
`define IOXP_RST_READ      8'h00
`define IOXP_CMD_UPPER_W   4

`endif

// *** inc/ioxp_pkg.sv ***
// types shared by the port data register core
package ioxp_pkg;
    typedef logic [7:0] ioxp_byte_t;

    // one port's pin signals
    typedef struct packed {
        ioxp_byte_t level;
        ioxp_byte_t drive;
        ioxp_byte_t enable;
    } ioxp_pins_s;

    // register access from the serial target engine
    typedef struct packed {
        logic       cmd_valid;
        ioxp_byte_t cmd_byte;
        logic       wr_valid;
        ioxp_byte_t wr_data;
        logic       rd_req;
    } ioxp_req_s;

    // answer to a read request
    typedef struct packed {
        logic       valid;
        logic       nack;
        logic       own;
        ioxp_byte_t data;
    } ioxp_rsp_s;

    // state of the core apart from the reset release synchronizer
    typedef struct packed {
        ioxp_byte_t [1:0] drive;
        ioxp_byte_t [1:0] invert;
        ioxp_byte_t [1:0] sync_a;
        ioxp_byte_t [1:0] sync_b;
        logic [3:0]       ptr;
        logic             cmd_set;
        ioxp_rsp_s        rsp;
    } ioxp_state_s;
endpackage : ioxp_pkg

// *** hw/ioxp_port_regs.sv ***
// input, output and polarity inversion registers of a two-port expander
`include "ioxp_params.svh"

module ioxp_port_regs (
    // clock and reset
    input  wire logic               mclk_i,
    input  wire logic               arst_n_i,
    // direction bits, held by the configuration registers
    input  wire logic [7:0]         port0_direction_bits_i,
    input  wire logic [7:0]         port1_direction_bits_i,
    // register access from the serial target engine
    input  wire ioxp_pkg::ioxp_req_s req_i,
    output ioxp_pkg::ioxp_rsp_s      rsp_o,
    output logic [3:0]              cmd_ptr_o,
    // port pins
    input  wire logic [7:0]         port0_pin_i,
    input  wire logic [7:0]         port1_pin_i,
    output ioxp_pkg::ioxp_pins_s     port0_pins_o,
    output ioxp_pkg::ioxp_pins_s     port1_pins_o,
    // resolved register views
    output logic [7:0]              port0_sampled_levels_o,
    output logic [7:0]              port1_sampled_levels_o
);
    import ioxp_pkg::*;

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic       rst_n;

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ----------------------------------------------------------------
    // pin view
    // ----------------------------------------------------------------
    ioxp_state_s state_reg;
    ioxp_state_s state_next;
    ioxp_byte_t  dir     [2];
    ioxp_byte_t  pin_in  [2];
    ioxp_byte_t  levels  [2];
    ioxp_pins_s  pins    [2];

    assign dir[0]    = port0_direction_bits_i;
    assign dir[1]    = port1_direction_bits_i;
    assign pin_in[0] = port0_pin_i;
    assign pin_in[1] = port1_pin_i;

    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_port
            // level seen whatever the direction; inversion only where input
            assign levels[p] = state_reg.sync_b[p] ^ (state_reg.invert[p] & dir[p]);
            assign pins[p].level  = levels[p];
            assign pins[p].drive  = state_reg.drive[p] & ~dir[p];
            assign pins[p].enable = ~dir[p];
        end
    endgenerate

    assign port0_pins_o           = pins[0];
    assign port1_pins_o           = pins[1];
    assign port0_sampled_levels_o = levels[0];
    assign port1_sampled_levels_o = levels[1];
    assign rsp_o                  = state_reg.rsp;
    assign cmd_ptr_o              = state_reg.ptr;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic       sel;
        logic [3:0] next_ptr;
        sel        = 1'b0;
        next_ptr   = 4'h0;
        state_next = state_reg;

        // pins sampled every clock, first stage feeds only the second
        state_next.sync_a[0] = port0_pin_i;
        state_next.sync_a[1] = port1_pin_i;
        state_next.sync_b    = state_reg.sync_a;

        state_next.rsp.valid = 1'b0;
        sel      = state_reg.ptr[0];
        next_ptr = {state_reg.ptr[3:1], ~state_reg.ptr[0]};

        if (req_i.cmd_valid) begin
            // upper nibble of the command byte is ignored
            state_next.ptr     = req_i.cmd_byte[3:0];
            state_next.cmd_set = 1'b1;
        end else if (req_i.wr_valid && state_reg.cmd_set) begin
            case (state_reg.ptr)
                `IOXP_OFS_DRIVE0, `IOXP_OFS_DRIVE1: begin
                    state_next.drive[sel] = req_i.wr_data;
                end
                `IOXP_OFS_INVERT0, `IOXP_OFS_INVERT1: begin
                    state_next.invert[sel] = req_i.wr_data;
                end
                default: begin
                    // input registers and foreign offsets: nothing stored
                    state_next.drive = state_reg.drive;
                end
            endcase
            state_next.ptr = next_ptr;
        end else if (req_i.rd_req) begin
            state_next.rsp.valid = 1'b1;
            state_next.rsp.data  = `IOXP_RST_READ;
            state_next.rsp.own   = 1'b0;
            state_next.rsp.nack  = ~state_reg.cmd_set;
            if (state_reg.cmd_set) begin
                state_next.rsp.own = (state_reg.ptr <= `IOXP_OFS_LAST_OWN);
                case (state_reg.ptr)
                    `IOXP_OFS_LEVEL0, `IOXP_OFS_LEVEL1: begin
                        state_next.rsp.data = levels[sel];
                    end
                    `IOXP_OFS_DRIVE0, `IOXP_OFS_DRIVE1: begin
                        state_next.rsp.data = state_reg.drive[sel];
                    end
                    `IOXP_OFS_INVERT0, `IOXP_OFS_INVERT1: begin
                        state_next.rsp.data = state_reg.invert[sel];
                    end
                    default: begin
                        state_next.rsp.data = `IOXP_RST_READ;
                    end
                endcase
                state_next.ptr = next_ptr;
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg           <= '0;
            state_reg.drive[0]  <= `IOXP_RST_DRIVE;
            state_reg.drive[1]  <= `IOXP_RST_DRIVE;
            state_reg.invert[0] <= `IOXP_RST_INVERT;
            state_reg.invert[1] <= `IOXP_RST_INVERT;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule : ioxp_port_regs

// *** testbench/ioxp_port_regs_props.sv ***
// checker for the port data register core
module ioxp_port_regs_props (
    input wire logic                mclk_i,
    input wire logic                arst_n_i,
    input wire logic [7:0]          port0_direction_bits_i,
    input wire logic [7:0]          port1_direction_bits_i,
    input wire ioxp_pkg::ioxp_req_s  req_i,
    input wire ioxp_pkg::ioxp_rsp_s  rsp_o,
    input wire logic [3:0]          cmd_ptr_o,
    input wire ioxp_pkg::ioxp_pins_s port0_pins_o,
    input wire ioxp_pkg::ioxp_pins_s port1_pins_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import ioxp_pkg::*;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    a_read_answer_next: assert property (req_i.rd_req && !req_i.cmd_valid && !req_i.wr_valid |=> rsp_o.valid)
        else $error("read not answered one cycle later");
    a_answer_only_read: assert property (rsp_o.valid |-> $past(req_i.rd_req && !req_i.cmd_valid && !req_i.wr_valid))
        else $error("answer without a read request");
    a_enable_from_dir: assert property ({port1_pins_o.enable, port0_pins_o.enable} == ~{port1_direction_bits_i, port0_direction_bits_i})
        else $error("pin enable does not follow direction");
    a_drive_on_inputs: assert property (((port0_pins_o.drive & port0_direction_bits_i) | (port1_pins_o.drive & port1_direction_bits_i)) == 8'h00)
        else $error("drive seen on an input pin");
    a_refused_zero: assert property (rsp_o.valid && rsp_o.nack |-> rsp_o.data == 8'h00 && !rsp_o.own)
        else $error("refused read carries data");
    a_pair_toggle: assert property (rsp_o.valid && !rsp_o.nack |-> cmd_ptr_o == ($past(cmd_ptr_o) ^ 4'h1))
        else $error("pointer did not alternate within pair");
    a_cmd_loads_ptr: assert property (req_i.cmd_valid |=> cmd_ptr_o == $past(req_i.cmd_byte[3:0]))
        else $error("command byte not taken as pointer");
    a_own_range: assert property (rsp_o.valid && !rsp_o.nack |-> rsp_o.own == ($past(cmd_ptr_o) <= 4'h5))
        else $error("own flag wrong for offset");
    c_refused: cover property (rsp_o.valid && rsp_o.nack);
    c_own_read: cover property (rsp_o.valid && rsp_o.own);
    c_command: cover property (req_i.cmd_valid);
    c_write: cover property (req_i.wr_valid && !req_i.cmd_valid);
endmodule : ioxp_port_regs_props

bind ioxp_port_regs ioxp_port_regs_props u_props (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .port0_direction_bits_i(port0_direction_bits_i), .port1_direction_bits_i(port1_direction_bits_i),
    .req_i(req_i), .rsp_o(rsp_o), .cmd_ptr_o(cmd_ptr_o), .port0_pins_o(port0_pins_o), .port1_pins_o(port1_pins_o));

// *** testbench/ioxp_pin_model.sv ***
// board side of one port: resolves device drive against an external source
module ioxp_pin_model (
    input  wire ioxp_pkg::ioxp_pins_s pins_i,
    input  wire logic [7:0]          ext_i,
    output logic [7:0]               level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import ioxp_pkg::*;
    assign level_o = (pins_i.enable & pins_i.drive) | (~pins_i.enable & ext_i);
endmodule : ioxp_pin_model

// *** testbench/io_expander_port_data_regs_bench.sv ***
// self-checking bench for the port data register core
module io_expander_port_data_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import ioxp_pkg::*;
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [7:0] dir0 = 8'hFF;
    logic [7:0] dir1 = 8'hFF;
    logic [7:0] pin0, pin1;
    logic [7:0] lvl0, lvl1;
    ioxp_req_s req = '0;
    ioxp_rsp_s rsp;
    ioxp_pins_s pins0, pins1;
    int miscompares = 0;
    int tests_run = 0;
    always #10 mclk_i = ~mclk_i;
    ioxp_port_regs DUT (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .port0_direction_bits_i(dir0),
        .port1_direction_bits_i(dir1), .req_i(req), .rsp_o(rsp), .cmd_ptr_o(), .port0_pin_i(pin0),
        .port1_pin_i(pin1), .port0_pins_o(pins0), .port1_pins_o(pins1), .port0_sampled_levels_o(lvl0),
        .port1_sampled_levels_o(lvl1));
    ioxp_pin_model u_pm0 (.pins_i(pins0), .ext_i(8'h3C), .level_o(pin0));
    ioxp_pin_model u_pm1 (.pins_i(pins1), .ext_i(8'hC3), .level_o(pin1));
    task chk(input string n, input logic [8:0] e, input logic [8:0] s);
        tests_run++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task cmd(input logic [7:0] b);
        @(posedge mclk_i) #1 req.cmd_valid = 1'b1; req.cmd_byte = b;
        @(posedge mclk_i) #1 req.cmd_valid = 1'b0;
    endtask : cmd
    task wr(input logic [7:0] d);
        @(posedge mclk_i) #1 req.wr_valid = 1'b1; req.wr_data = d;
        @(posedge mclk_i) #1 req.wr_valid = 1'b0;
    endtask : wr
    task rd(input logic [8:0] e);
        @(posedge mclk_i) #1 req.rd_req = 1'b1;
        @(posedge mclk_i) #1 req.rd_req = 1'b0;
        chk("read valid", 9'h001, {8'h00, rsp.valid});
        chk("read nack and data", e, {rsp.nack, rsp.data});
    endtask : rd
    task settle;
        repeat (4) @(posedge mclk_i);
        #1;
    endtask : settle
    task final_report;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report
    initial begin
        #200000;
        miscompares++;
        final_report();
    end
    initial begin
        repeat (3) @(posedge mclk_i);
        #1 arst_n_i = 1'b1;
        repeat (3) @(posedge mclk_i);
        rd(9'h100);
        cmd(8'h02); rd(9'h0FF); rd(9'h0FF);
        cmd(8'h04); rd(9'h000); rd(9'h000);
        cmd(8'h00); rd(9'h03C); rd(9'h0C3);
        cmd(8'h02); wr(8'h5A); wr(8'hA5); dir0 = 8'h00; dir1 = 8'h00; settle();
        chk("pin drive", {1'b0, pins0.drive}, 9'h05A);
        chk("pin enable", {1'b0, pins1.enable}, 9'h0FF);
        cmd(8'h00); rd(9'h05A); rd(9'h0A5);
        dir0 = 8'hF0; settle();
        chk("masked drive", {1'b0, pins0.drive}, 9'h00A);
        cmd(8'h02); rd(9'h05A); rd(9'h0A5);
        cmd(8'h04); wr(8'h0F); wr(8'hFF); cmd(8'h04); rd(9'h00F); rd(9'h0FF);
        dir0 = 8'h0F; settle();
        chk("sampled level0", {1'b0, lvl0}, 9'h053);
        chk("pin level0", {1'b0, pins0.level}, 9'h053);
        chk("sampled level1", {1'b0, lvl1}, 9'h0A5);
        cmd(8'h00); rd(9'h053); rd(9'h0A5);
        cmd(8'h00); wr(8'h77); wr(8'h77); cmd(8'h02); rd(9'h05A); rd(9'h0A5);
        cmd(8'h04); rd(9'h00F);
        final_report();
    end
endmodule : io_expander_port_data_regs_bench
